// [logic/ocm_pkg.sv]
// Constants and types shared by the oscillator trim and clock multiplier
package ocm_pkg;

    // ------------------------------------------------------------------
    // Register page and addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] OCM_PAGE         = 8'h0F;
    localparam logic [7:0] OCM_ADDR_MULCTL  = 8'h97;
    localparam logic [7:0] OCM_ADDR_FINE    = 8'h9E;
    localparam logic [7:0] OCM_ADDR_COARSE  = 8'hA2;

    // ------------------------------------------------------------------
    // Field positions of the multiplier control register
    // ------------------------------------------------------------------
    localparam int OCM_BIT_EN     = 7;
    localparam int OCM_BIT_INIT   = 6;
    localparam int OCM_BIT_LOCKED = 5;
    localparam int OCM_SCALE_HI   = 4;
    localparam int OCM_SCALE_LO   = 2;
    localparam int OCM_INSEL_HI   = 1;
    localparam int OCM_INSEL_LO   = 0;

    localparam int OCM_COARSE_W = 7;
    localparam int OCM_FINE_W   = 6;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] OCM_MULCTL_RST = 8'h00;
    localparam logic [6:0] OCM_COARSE_DEF = 7'h40;
    localparam logic [5:0] OCM_FINE_DEF   = 6'h20;

    // ------------------------------------------------------------------
    // Multiplier timing and encodings
    // ------------------------------------------------------------------
    localparam logic [3:0] OCM_BURST_PULSES = 4'h4;
    localparam logic [3:0] OCM_BURST_MAX    = 4'hC;
    localparam int         OCM_LOCK_CYCLES  = 64;
    localparam logic [2:0] OCM_PASS_COUNT   = 3'h2;

    localparam logic [1:0] OCM_IN_INT_HALF = 2'h0;
    localparam logic [1:0] OCM_IN_EXT      = 2'h1;
    localparam logic [1:0] OCM_IN_EXT_HALF = 2'h2;

    localparam logic [1:0] OCM_SYS_INT  = 2'h0;
    localparam logic [1:0] OCM_SYS_EXT  = 2'h1;
    localparam logic [1:0] OCM_SYS_MULT = 2'h2;

    typedef enum logic [1:0] {
        OCM_ST_OFF  = 2'b00,
        OCM_ST_IDLE = 2'b01,
        OCM_ST_LOCK = 2'b11,
        OCM_ST_RDY  = 2'b10
    } ocm_state_e;

    // Divisor N of the 2/N scaling; zero means pass every pulse
    function automatic logic [2:0] ocm_scale_div(input logic [2:0] code);
        logic [2:0] n;
        n = (code < 3'h3) ? 3'h0 : code;
        return n;
    endfunction

endpackage

// [logic/ocm_scale.sv]
// Output scaler: passes two of every N multiplier pulses
`timescale 1ns/1ps
`default_nettype none
module ocm_scale (
    input  wire logic                core_clk,
    input  wire logic                rst_b,
    input  wire logic                tick_in,
    input  wire logic [2:0]          scale_code,
    output logic                     tick_out
);
    import ocm_pkg::*;

    typedef struct packed {
        logic [2:0] cnt;
        logic       out;
    } ocm_scale_s;

    ocm_scale_s s_q;
    ocm_scale_s s_d;
    logic [2:0] div;

    always_comb begin
        s_d = s_q;
        div = ocm_scale_div(scale_code);
        s_d.out = 1'b0;
        if (tick_in) begin
            if (div == 3'h0) begin
                s_d.out = 1'b1;
                s_d.cnt = 3'h0;
            end else begin
                s_d.out = (s_q.cnt < OCM_PASS_COUNT);
                s_d.cnt = (s_q.cnt >= div - 3'h1) ? 3'h0 : s_q.cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick_out = s_q.out;

    // The second pulse of each window is passed when the scale code is 4
    AST_SCALE_HALF: assert property (@(posedge core_clk) disable iff (!rst_b)
        (tick_in && scale_code == 3'h4 && s_q.cnt == 3'h1)
        |=> tick_out)
        else $error("scaler dropped second pulse of window");

endmodule
`default_nettype wire

// [logic/ocm_top.sv]
// Oscillator trim registers and clock multiplier behind the register port
`timescale 1ns/1ps
`default_nettype none
module ocm_top #(
    parameter logic [6:0] COARSE_FACTORY = ocm_pkg::OCM_COARSE_DEF,
    parameter logic [5:0] FINE_FACTORY   = ocm_pkg::OCM_FINE_DEF,
    parameter int         LOCK_CYCLES    = ocm_pkg::OCM_LOCK_CYCLES
) (
    input  wire logic                core_clk,
    input  wire logic                rst_b,
    input  wire logic [7:0]          sfr_page,
    input  wire logic [7:0]          sfr_addr,
    input  wire logic                sfr_wr,
    input  wire logic                sfr_rd,
    input  wire logic [7:0]          sfr_wdata,
    output logic      [7:0]          sfr_rdata,
    input  wire logic                int_osc_in,
    input  wire logic                ext_osc_in,
    input  wire logic                int_div_tick,
    input  wire logic [1:0]          system_clock_source_select,
    output logic      [6:0]          coarse_trim,
    output logic      [5:0]          fine_trim,
    output logic                     mult_clk_tick,
    output logic                     mult_locked,
    output logic                     system_clock_tick
);
    import ocm_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        ocm_state_e st;
        logic [2:0] scale;
        logic [1:0] insel;
        logic [6:0] coarse;
        logic [5:0] fine;
        logic [7:0] lock_cnt;
        logic       int_prev;
        logic       ext_prev;
        logic       int_half;
        logic       ext_half;
        logic [3:0] burst;
        logic       phase;
        logic [7:0] rdata;
        logic       sys_tick;
    } ocm_top_s;

    ocm_top_s s_q;
    ocm_top_s s_d;

    logic       sel_pg;
    logic       wr_ctl;
    logic       src_rise;
    logic       int_rise;
    logic       ext_rise;
    logic       fast_tick;
    logic       scaled_tick;
    logic       running;
    logic [7:0] ctl_rd;

    localparam logic [7:0] LOCK_LAST = 8'(LOCK_CYCLES - 1);

    always_comb begin
        s_d      = s_q;
        sel_pg   = (sfr_page == OCM_PAGE);
        wr_ctl   = sfr_wr && sel_pg && (sfr_addr == OCM_ADDR_MULCTL);
        int_rise = int_osc_in && !s_q.int_prev;
        ext_rise = ext_osc_in && !s_q.ext_prev;
        running  = (s_q.st == OCM_ST_LOCK) || (s_q.st == OCM_ST_RDY);
        ctl_rd   = {s_q.st != OCM_ST_OFF, running, s_q.st == OCM_ST_RDY,
                    s_q.scale, s_q.insel};

        // --------------------------------------------------------------
        // Input edge detect and halving
        // --------------------------------------------------------------
        s_d.int_prev = int_osc_in;
        s_d.ext_prev = ext_osc_in;
        if (int_rise) begin
            s_d.int_half = !s_q.int_half;
        end
        if (ext_rise) begin
            s_d.ext_half = !s_q.ext_half;
        end
        unique case (s_q.insel)
            OCM_IN_INT_HALF: src_rise = int_rise && !s_q.int_half;
            OCM_IN_EXT:      src_rise = ext_rise;
            OCM_IN_EXT_HALF: src_rise = ext_rise && !s_q.ext_half;
            default:         src_rise = 1'b0;
        endcase

        // --------------------------------------------------------------
        // Burst of four fast pulses per input edge, then hold
        // --------------------------------------------------------------
        fast_tick = running && (s_q.burst != 4'h0) && s_q.phase;
        if (!running) begin
            s_d.burst = 4'h0;
            s_d.phase = 1'b0;
        end else begin
            if (s_q.burst != 4'h0) begin
                s_d.phase = !s_q.phase;
            end
            if (src_rise && s_q.burst <= OCM_BURST_MAX - OCM_BURST_PULSES) begin
                s_d.burst = s_q.burst + OCM_BURST_PULSES - {3'h0, fast_tick};
            end else if (fast_tick) begin
                s_d.burst = s_q.burst - 4'h1;
            end
        end

        // --------------------------------------------------------------
        // Multiplier state
        // --------------------------------------------------------------
        unique case (s_q.st)
            OCM_ST_LOCK: begin
                s_d.lock_cnt = s_q.lock_cnt + 8'h01;
                if (s_q.lock_cnt == LOCK_LAST) begin
                    s_d.st = OCM_ST_RDY;
                end
            end
            OCM_ST_OFF, OCM_ST_IDLE, OCM_ST_RDY: begin
            end
        endcase

        // --------------------------------------------------------------
        // Register writes
        // --------------------------------------------------------------
        if (wr_ctl) begin
            s_d.scale = sfr_wdata[OCM_SCALE_HI:OCM_SCALE_LO];
            s_d.insel = sfr_wdata[OCM_INSEL_HI:OCM_INSEL_LO];
            if (!sfr_wdata[OCM_BIT_EN]) begin
                s_d.st = OCM_ST_OFF;
            end else if (!sfr_wdata[OCM_BIT_INIT]) begin
                s_d.st = OCM_ST_IDLE;
            end else if (s_q.st == OCM_ST_IDLE) begin
                s_d.st       = OCM_ST_LOCK;
                s_d.lock_cnt = 8'h00;
            end else if (s_q.st == OCM_ST_OFF) begin
                s_d.st = OCM_ST_IDLE;
            end
        end
        if (sfr_wr && sel_pg && sfr_addr == OCM_ADDR_COARSE) begin
            s_d.coarse = sfr_wdata[OCM_COARSE_W-1:0];
        end
        if (sfr_wr && sel_pg && sfr_addr == OCM_ADDR_FINE) begin
            s_d.fine = sfr_wdata[OCM_FINE_W-1:0];
        end

        // --------------------------------------------------------------
        // Register reads, held until the next read
        // --------------------------------------------------------------
        if (sfr_rd) begin
            s_d.rdata = 8'h00;
            if (sel_pg) begin
                unique case (sfr_addr)
                    OCM_ADDR_MULCTL: s_d.rdata = ctl_rd;
                    OCM_ADDR_COARSE: s_d.rdata = {1'b0, s_q.coarse};
                    OCM_ADDR_FINE:   s_d.rdata = {2'b00, s_q.fine};
                    default:         s_d.rdata = 8'h00;
                endcase
            end
        end

        // --------------------------------------------------------------
        // System clock source
        // --------------------------------------------------------------
        unique case (system_clock_source_select)
            OCM_SYS_INT:  s_d.sys_tick = int_div_tick;
            OCM_SYS_EXT:  s_d.sys_tick = ext_rise;
            OCM_SYS_MULT: s_d.sys_tick = scaled_tick;
            default:      s_d.sys_tick = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q        <= '0;
            s_q.st     <= OCM_ST_OFF;
            s_q.coarse <= COARSE_FACTORY;
            s_q.fine   <= FINE_FACTORY;
        end else begin
            s_q <= s_d;
        end
    end

    ocm_scale u_scale (
        .core_clk   (core_clk),
        .rst_b      (rst_b),
        .tick_in    (fast_tick),
        .scale_code (s_q.scale),
        .tick_out   (scaled_tick)
    );

    assign sfr_rdata         = s_q.rdata;
    assign coarse_trim       = s_q.coarse;
    assign fine_trim         = s_q.fine;
    assign mult_clk_tick     = scaled_tick;
    assign mult_locked       = (s_q.st == OCM_ST_RDY);
    assign system_clock_tick = s_q.sys_tick;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence seq_enable;
        wr_ctl && sfr_wdata[OCM_BIT_EN] && !sfr_wdata[OCM_BIT_INIT];
    endsequence
    sequence seq_init;
        wr_ctl && sfr_wdata[OCM_BIT_EN] && sfr_wdata[OCM_BIT_INIT];
    endsequence

    AST_ENABLE_IDLE: assert property (
        seq_enable |=> s_q.st == OCM_ST_IDLE && !mult_locked)
        else $error("enable did not leave multiplier idle");
    AST_LOCK_AFTER_INIT: assert property (
        (seq_init and s_q.st == OCM_ST_IDLE)
        ##1 (!wr_ctl)[*2] |-> !mult_locked)
        else $error("lock flag rose too early");
    AST_LOCK_TIME: assert property (
        (s_q.st == OCM_ST_LOCK && s_q.lock_cnt == LOCK_LAST && !wr_ctl)
        |=> mult_locked)
        else $error("lock flag missing after lock count");
    AST_LOCK_CLEAR: assert property (
        (wr_ctl && !sfr_wdata[OCM_BIT_EN]) |=> !mult_locked && !running)
        else $error("lock flag kept after disable");
    AST_INIT_FIRST_ZERO: assert property (
        (seq_init and s_q.st == OCM_ST_OFF) |=> s_q.st == OCM_ST_IDLE)
        else $error("initialise accepted before enable");
    AST_COARSE_READ: assert property (
        (sfr_rd && sel_pg && sfr_addr == OCM_ADDR_COARSE)
        |=> sfr_rdata == {1'b0, $past(s_q.coarse)})
        else $error("coarse trim read wrong");
    AST_FINE_WRITE: assert property (
        (sfr_wr && sel_pg && sfr_addr == OCM_ADDR_FINE)
        |=> fine_trim == $past(sfr_wdata[OCM_FINE_W-1:0]))
        else $error("fine trim not written");
    AST_CTL_READ: assert property (
        (sfr_rd && sel_pg && sfr_addr == OCM_ADDR_MULCTL)
        |=> sfr_rdata[OCM_BIT_LOCKED] == $past(mult_locked))
        else $error("control read lock bit wrong");
    AST_BURST_FOUR: assert property (
        (running && s_q.burst == 4'h0 && src_rise && !wr_ctl)
        |=> s_q.burst == OCM_BURST_PULSES)
        else $error("burst not loaded with four pulses");
    AST_SYS_MULT: assert property (
        (system_clock_source_select == OCM_SYS_MULT)
        |=> system_clock_tick == $past(scaled_tick))
        else $error("system clock not from multiplier");
    AST_NO_TICK_OFF: assert property (!running |=> !mult_clk_tick)
        else $error("multiplier pulses while not running");

endmodule
`default_nettype wire

// [verification/ocm_top_tb.sv]
// Self-checking testbench for the oscillator trim and clock multiplier
`timescale 1ns/1ps
`default_nettype none
module ocm_top_tb;
    import ocm_pkg::*;

    localparam int LOCK_N = 4;
    localparam int EDGES  = 210;

    logic       core_clk;
    logic       rst_b;
    logic [7:0] sfr_page;
    logic [7:0] sfr_addr;
    logic       sfr_wr;
    logic       sfr_rd;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic       int_osc_in;
    logic       ext_osc_in;
    logic       int_div_tick;
    logic [1:0] system_clock_source_select;
    logic [6:0] coarse_trim;
    logic [5:0] fine_trim;
    logic       mult_clk_tick;
    logic       mult_locked;
    logic       system_clock_tick;
    int         err_total;
    int         n_tests;
    int         n_mult;
    int         n_sys;
    logic       count_en;
    logic [7:0] rd_v;

    ocm_top #(.LOCK_CYCLES(LOCK_N)) uut (
        .core_clk             (core_clk),
        .rst_b                (rst_b),
        .sfr_page             (sfr_page),
        .sfr_addr             (sfr_addr),
        .sfr_wr               (sfr_wr),
        .sfr_rd               (sfr_rd),
        .sfr_wdata            (sfr_wdata),
        .sfr_rdata            (sfr_rdata),
        .int_osc_in           (int_osc_in),
        .ext_osc_in           (ext_osc_in),
        .int_div_tick         (int_div_tick),
        .system_clock_source_select (system_clock_source_select),
        .coarse_trim          (coarse_trim),
        .fine_trim            (fine_trim),
        .mult_clk_tick        (mult_clk_tick),
        .mult_locked          (mult_locked),
        .system_clock_tick    (system_clock_tick)
    );

    // ------------------------------------------------------------------
    // Clock, tick counters, shared tasks
    // ------------------------------------------------------------------
    always #5 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        if (count_en) begin
            if (mult_clk_tick === 1'b1) n_mult++;
            if (system_clock_tick === 1'b1) n_sys++;
        end
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1 sfr_wr = 1'b1; sfr_addr = a; sfr_wdata = d;
        @(posedge core_clk);
        #1 sfr_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        #1 sfr_rd = 1'b1; sfr_addr = a;
        @(posedge core_clk);
        #1 sfr_rd = 1'b0;
        rd_v = sfr_rdata;
    endtask

    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        rd(OCM_ADDR_MULCTL); check("ctl_rst", rd_v, 8'h00);
        rd(OCM_ADDR_COARSE); check("crs_rst", rd_v, {1'b0, OCM_COARSE_DEF});
        rd(OCM_ADDR_FINE); check("fin_rst", rd_v, {2'b00, OCM_FINE_DEF});
        check("crs_port", coarse_trim, OCM_COARSE_DEF);
        check("fin_port", fine_trim, OCM_FINE_DEF);
        check("lock_rst", mult_locked, 1'b0);
    endtask

    task automatic t_trim;
        wr(OCM_ADDR_COARSE, 8'hFF);
        rd(OCM_ADDR_COARSE); check("crs_max", rd_v, 8'h7F);
        check("crs_pmax", coarse_trim, 7'h7F);
        wr(OCM_ADDR_COARSE, 8'h00);
        rd(OCM_ADDR_COARSE); check("crs_min", rd_v, 8'h00);
        wr(OCM_ADDR_FINE, 8'hFF);
        rd(OCM_ADDR_FINE); check("fin_max", rd_v, 8'h3F);
        check("fin_pmax", fine_trim, 6'h3F);
        sfr_page = 8'h00;
        wr(OCM_ADDR_COARSE, 8'h55);
        sfr_page = OCM_PAGE;
        check("crs_page", coarse_trim, 7'h00);
        rd(8'h90); check("unmapped", rd_v, 8'h00);
        wr(OCM_ADDR_MULCTL, 8'hC0);
        rd(OCM_ADDR_MULCTL); check("init_off", rd_v, 8'h80);
        wr(OCM_ADDR_MULCTL, 8'h00);
    endtask

    task automatic t_system_clock;
        system_clock_source_select = OCM_SYS_INT;
        n_sys = 0; count_en = 1'b1;
        repeat (5) begin
            int_div_tick = 1'b1; cyc(1); int_div_tick = 1'b0; cyc(3);
        end
        cyc(3); count_en = 1'b0;
        check("sys_int", n_sys, 5);
        system_clock_source_select = 2'h3;
        n_sys = 0; count_en = 1'b1;
        repeat (5) begin
            int_div_tick = 1'b1; cyc(1); int_div_tick = 1'b0; cyc(3);
        end
        cyc(3); count_en = 1'b0;
        check("sys_none", n_sys, 0);
        system_clock_source_select = OCM_SYS_EXT;
        n_sys = 0; count_en = 1'b1;
        repeat (4) begin
            ext_osc_in = 1'b1; cyc(2); ext_osc_in = 1'b0; cyc(2);
        end
        cyc(3); count_en = 1'b0;
        check("sys_ext", n_sys, 4);
        system_clock_source_select = OCM_SYS_MULT;
    endtask

    task automatic run_mult(input logic [1:0] insel, input logic [2:0] code);
        logic [7:0] f;
        int         base;
        int         exp;
        f = {3'b000, code, insel};
        wr(OCM_ADDR_MULCTL, 8'h00);
        wr(OCM_ADDR_MULCTL, {6'h00, insel});
        wr(OCM_ADDR_MULCTL, f);
        wr(OCM_ADDR_MULCTL, 8'h80 | f);
        rd(OCM_ADDR_MULCTL); check("ctl_en", rd_v, 8'h80 | f);
        cyc(510);
        wr(OCM_ADDR_MULCTL, 8'hC0 | f);
        check("lock_early", mult_locked, 1'b0);
        for (int i = 0; i < 50 && mult_locked !== 1'b1; i++) cyc(1);
        check("locked", mult_locked, 1'b1);
        rd(OCM_ADDR_MULCTL); check("ctl_lock", rd_v, 8'hE0 | f);
        n_mult = 0; n_sys = 0; count_en = 1'b1;
        for (int i = 0; i < EDGES * 20; i++) begin
            ext_osc_in = (i % 20) < 10;
            int_osc_in = (i % 5) < 2;
            cyc(1);
        end
        ext_osc_in = 1'b0; int_osc_in = 1'b0;
        cyc(30); count_en = 1'b0;
        case (insel)
            OCM_IN_INT_HALF: base = 8 * EDGES;
            OCM_IN_EXT:      base = 4 * EDGES;
            OCM_IN_EXT_HALF: base = 2 * EDGES;
            default:         base = 0;
        endcase
        exp = (code < 3) ? base : base * 2 / code;
        check("mult_cnt", n_mult, exp);
        check("sys_mult", n_sys, exp);
        wr(OCM_ADDR_MULCTL, 8'h00);
        cyc(1);
        check("lock_clr", mult_locked, 1'b0);
        rd(OCM_ADDR_MULCTL); check("ctl_clr", rd_v, 8'h00);
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        core_clk = 1'b0; rst_b = 1'b0; sfr_page = OCM_PAGE;
        sfr_addr = 8'h00; sfr_wr = 1'b0; sfr_rd = 1'b0;
        sfr_wdata = 8'h00; int_osc_in = 1'b0; ext_osc_in = 1'b0;
        int_div_tick = 1'b0; system_clock_source_select = OCM_SYS_MULT;
        err_total = 0; n_tests = 0; n_mult = 0; n_sys = 0;
        count_en = 1'b0; rd_v = 8'h00;
        cyc(5);
        rst_b = 1'b1;
        t_reset;
        t_trim;
        t_system_clock;
        for (int c = 0; c < 8; c++) run_mult(OCM_IN_EXT, 3'(c));
        run_mult(OCM_IN_INT_HALF, 3'h7);
        run_mult(OCM_IN_EXT_HALF, 3'h5);
        run_mult(2'h3, 3'h0);
        stop_test;
    end

    initial begin
        #1_000_000;
        err_total++;
        stop_test;
    end
endmodule
`default_nettype wire
